// ==== design/cpu_register_file_ccr.v ====
// cpu programmer register set with condition codes and reset vector load
`timescale 1ns/1ns
`include "cpu_regs_map.vh"

module cpu_register_file_ccr (
  input wire core_clk_i,
  input wire rst_b_i,
  // software port
  input wire [2:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // reset vector fetch
  output reg vec_fetch_o,
  output reg [15:0] vec_addr_o,
  input wire [7:0] vec_data_i,
  // sequencer controls
  input wire [3:0] alu_op_i,
  input wire [7:0] operand_i,
  input wire alu_to_index_i,
  input wire fetch_i,
  input wire pc_load_i,
  input wire [15:0] pc_target_i,
  input wire [2:0] branch_cond_i,
  input wire branch_i,
  input wire [7:0] branch_offset_i,
  input wire push_i,
  input wire pull_i,
  input wire [7:0] pull_data_i,
  input wire [2:0] pull_sel_i,
  input wire stack_reset_instr_i,
  input wire clear_mask_instr_i,
  input wire set_mask_instr_i,
  input wire wait_stop_instr_i,
  input wire [1:0] addr_mode_i,
  input wire [15:0] offset_i,
  input wire [3:0] irq_req_i,
  input wire stacking_done_i,
  // outputs to the sequencer
  output reg [7:0] accumulator_o,
  output reg [15:0] index_pair_o,
  output reg [15:0] stack_pointer_o,
  output reg [15:0] program_counter_o,
  output reg [7:0] condition_codes_o,
  output reg [15:0] operand_addr_o,
  output reg irq_take_o,
  output reg [1:0] irq_sel_o,
  output reg branch_taken_o,
  output reg vector_ready_o
);

// ----------------------------------------
// vector load sequencer
// ----------------------------------------
localparam VS_HIGH = 2'b00;
localparam VS_LOW = 2'b01;
localparam VS_DONE = 2'b10;

reg [1:0] vec_state;
reg [7:0] accumulator;
reg [7:0] index_upper;
reg [7:0] index_lower;
reg [15:0] stack_pointer;
reg [15:0] program_counter;
reg [7:0] flags;
reg [7:0] next_acc;
reg [7:0] next_flags;
reg [8:0] sum;
reg [4:0] half;
reg [7:0] result;
reg writes_result;
reg carry_in;
reg [7:0] adj;
reg cond_true;
reg [1:0] top_irq;
reg any_irq;
integer k;

// the two fixed bits are forced on the way out, whatever the stored flags hold
wire [7:0] cc_view = flags | `CC_FIXED_ONES;
wire alu_src_x = alu_to_index_i;
wire [7:0] alu_a = alu_src_x ? index_lower : accumulator;

// ----------------------------------------
// arithmetic and flag evaluation
// ----------------------------------------
always @* begin
  next_flags = flags;
  carry_in = flags[`CC_CARRY];
  sum = 9'h000;
  half = 5'h00;
  result = alu_a;
  writes_result = 1'b1;
  adj = 8'h00;
  case (alu_op_i)
    `OP_ADD, `OP_ADC: begin
      sum = {1'b0, alu_a} + {1'b0, operand_i} +
        {8'h00, (alu_op_i == `OP_ADC) & carry_in};
      half = {1'b0, alu_a[3:0]} + {1'b0, operand_i[3:0]} +
        {4'h0, (alu_op_i == `OP_ADC) & carry_in};
      result = sum[7:0];
      next_flags[`CC_HALF] = half[4];
      next_flags[`CC_CARRY] = sum[8];
      next_flags[`CC_OVERFLOW] = (alu_a[7] == operand_i[7]) &
        (result[7] != alu_a[7]);
    end
    // bit test subtracts for flags only; the target keeps its value
    `OP_SUB, `OP_SBC, `OP_BIT_TEST: begin
      // sum[8] is the borrow out, which lands in the carry flag
      sum = {1'b0, alu_a} - {1'b0, operand_i} -
        {8'h00, (alu_op_i == `OP_SBC) & carry_in};
      result = sum[7:0];
      next_flags[`CC_CARRY] = sum[8];
      next_flags[`CC_OVERFLOW] = (alu_a[7] != operand_i[7]) &
        (result[7] != alu_a[7]);
      writes_result = (alu_op_i != `OP_BIT_TEST);
    end
    `OP_AND: begin
      result = alu_a & operand_i;
      next_flags[`CC_OVERFLOW] = 1'b0;
    end
    `OP_OR: begin
      result = alu_a | operand_i;
      next_flags[`CC_OVERFLOW] = 1'b0;
    end
    `OP_EOR: begin
      result = alu_a ^ operand_i;
      next_flags[`CC_OVERFLOW] = 1'b0;
    end
    `OP_LOAD: begin
      result = operand_i;
      next_flags[`CC_OVERFLOW] = 1'b0;
    end
    `OP_ASL, `OP_LSR, `OP_ASR, `OP_ROL, `OP_ROR: begin
      case (alu_op_i)
        `OP_ASL: result = {alu_a[6:0], 1'b0};
        `OP_ROL: result = {alu_a[6:0], carry_in};
        `OP_LSR: result = {1'b0, alu_a[7:1]};
        `OP_ASR: result = {alu_a[7], alu_a[7:1]};
        default: result = {carry_in, alu_a[7:1]};
      endcase
      next_flags[`CC_CARRY] = (alu_op_i == `OP_ASL ||
        alu_op_i == `OP_ROL) ? alu_a[7] : alu_a[0];
      next_flags[`CC_OVERFLOW] = result[7] ^
        next_flags[`CC_CARRY];
    end
    `OP_DAA: begin
      // correction picked from half carry, carry and the digit values
      // assumes the previous op was an add; no subtract form
      if (flags[`CC_HALF] || alu_a[3:0] > 4'h9)
        adj[3:0] = 4'h6;
      if (carry_in || alu_a > 8'h99) begin
        adj[7:4] = 4'h6;
        next_flags[`CC_CARRY] = 1'b1;
      end
      result = alu_a + adj;
    end
    default: begin
      writes_result = 1'b0;
    end
  endcase
  if (alu_op_i != `OP_NONE) begin
    next_flags[`CC_NEGATIVE] = result[7];
    next_flags[`CC_ZERO] = (result == 8'h00);
  end
  next_acc = result;
end

// ----------------------------------------
// branch condition and interrupt priority
// ----------------------------------------
always @* begin
  case (branch_cond_i)
    `BR_ALWAYS: cond_true = 1'b1;
    // signed branches look at overflow
    `BR_GREATER: cond_true = ~(flags[`CC_ZERO] |
      (flags[`CC_NEGATIVE] ^ flags[`CC_OVERFLOW]));
    `BR_GREATER_EQUAL: cond_true = ~(flags[`CC_NEGATIVE] ^
      flags[`CC_OVERFLOW]);
    `BR_LESS_EQUAL: cond_true = flags[`CC_ZERO] |
      (flags[`CC_NEGATIVE] ^ flags[`CC_OVERFLOW]);
    `BR_LESS: cond_true = flags[`CC_NEGATIVE] ^ flags[`CC_OVERFLOW];
    `BR_EQUAL: cond_true = flags[`CC_ZERO];
    `BR_NOT_EQUAL: cond_true = ~flags[`CC_ZERO];
    default: cond_true = flags[`CC_CARRY];
  endcase
  // lowest index wins as highest priority
  // requests are looked at afresh each edge; nothing latches them
  top_irq = 2'b00;
  any_irq = 1'b0;
  for (k = 3; k >= 0; k = k - 1) begin
    if (irq_req_i[k]) begin
      top_irq = k[1:0];
      any_irq = 1'b1;
    end
  end
end

// ----------------------------------------
// register updates
// ----------------------------------------
always @(posedge core_clk_i or negedge rst_b_i) begin
  if (!rst_b_i) begin
    vec_state <= VS_HIGH;
    accumulator <= 8'h00;
    index_upper <= 8'h00;
    index_lower <= 8'h00;
    stack_pointer <= `STACK_RESET;
    program_counter <= 16'h0000;
    flags <= `CC_RESET;
  end else begin
    // vector load, high byte first
    case (vec_state)
      VS_HIGH: begin
        program_counter[15:8] <= vec_data_i;
        vec_state <= VS_LOW;
      end
      VS_LOW: begin
        program_counter[7:0] <= vec_data_i;
        vec_state <= VS_DONE;
      end
      // register updates from sequencer and software inputs wait until both bytes are in; reads do not wait
      VS_DONE: begin
        // one update per edge; later lines win
        if (writes_result && alu_op_i != `OP_NONE) begin
          if (alu_to_index_i)
            index_lower <= next_acc;
          else
            accumulator <= next_acc;
        end
        flags <= next_flags;
        // relative target counts from the byte after the offset
        if (pc_load_i)
          program_counter <= pc_target_i;
        else if (branch_i && cond_true)
          program_counter <= program_counter + 16'h0001 +
            {{8{branch_offset_i[7]}}, branch_offset_i};
        else if (fetch_i)
          program_counter <= program_counter + 16'h0001;
        // push only moves the pointer; the byte goes out elsewhere
        if (stack_reset_instr_i)
          stack_pointer[7:0] <= `STACK_LOW_RESET;
        else if (push_i)
          stack_pointer <= stack_pointer - 16'h0001;
        else if (pull_i)
          stack_pointer <= stack_pointer + 16'h0001;
        if (pull_i) begin
          // pulls restore mask too; upper index only by own pull
          case (pull_sel_i)
            `REG_ACCUMULATOR: accumulator <= pull_data_i;
            `REG_INDEX_UPPER: index_upper <= pull_data_i;
            `REG_INDEX_LOWER: index_lower <= pull_data_i;
            `REG_CONDITION_CODES:
              flags <= pull_data_i;
            default: ;
          endcase
        end
        // mask set once stacking is done or by its set instruction; set wins over clear
        if (stacking_done_i || set_mask_instr_i)
          flags[`CC_MASK] <= 1'b1;
        else if (clear_mask_instr_i || wait_stop_instr_i)
          flags[`CC_MASK] <= 1'b0;
        // software port comes last, so it wins over alu and pull
        if (reg_wr_i) begin
          case (reg_addr_i)
            `REG_ACCUMULATOR: accumulator <= reg_wdata_i;
            `REG_INDEX_UPPER: index_upper <= reg_wdata_i;
            `REG_INDEX_LOWER: index_lower <= reg_wdata_i;
            `REG_STACK_HIGH: stack_pointer[15:8] <= reg_wdata_i;
            `REG_STACK_LOW: stack_pointer[7:0] <= reg_wdata_i;
            `REG_PC_HIGH: program_counter[15:8] <= reg_wdata_i;
            `REG_PC_LOW: program_counter[7:0] <= reg_wdata_i;
            // mask bit is kept; it moves only by mask and wait/stop instructions, stacking and pulls
            default: flags <= {reg_wdata_i[7:4], flags[`CC_MASK],
              reg_wdata_i[2:0]};
          endcase
        end
      end
      default: vec_state <= VS_HIGH;
    endcase
  end
end

// ----------------------------------------
// registered outputs
// ----------------------------------------
always @(posedge core_clk_i or negedge rst_b_i) begin
  if (!rst_b_i) begin
    reg_rdata_o <= 8'h00;
    vec_fetch_o <= 1'b1;
    vec_addr_o <= `VEC_HIGH_ADDR;
    accumulator_o <= 8'h00;
    index_pair_o <= 16'h0000;
    stack_pointer_o <= `STACK_RESET;
    program_counter_o <= 16'h0000;
    condition_codes_o <= `CC_RESET;
    operand_addr_o <= 16'h0000;
    irq_take_o <= 1'b0;
    irq_sel_o <= 2'b00;
    branch_taken_o <= 1'b0;
    vector_ready_o <= 1'b0;
  end else begin
    // high from reset until the low vector byte has been taken
    vec_fetch_o <= (vec_state == VS_HIGH);
    // the address leads the state by one edge, so each byte is settled
    // when its state takes it
    case (vec_state)
      VS_HIGH: vec_addr_o <= `VEC_LOW_ADDR;
      default: vec_addr_o <= `VEC_HIGH_ADDR;
    endcase
    vector_ready_o <= (vec_state == VS_DONE);
    accumulator_o <= accumulator;
    index_pair_o <= {index_upper, index_lower};
    stack_pointer_o <= stack_pointer;
    program_counter_o <= program_counter;
    condition_codes_o <= cc_view;
    case (addr_mode_i)
      2'b01: operand_addr_o <= {index_upper, index_lower} +
        offset_i;
      2'b10: operand_addr_o <= stack_pointer + offset_i;
      2'b11: operand_addr_o <= stack_pointer +
        {8'h00, offset_i[7:0]};
      default: operand_addr_o <= offset_i;
    endcase
    // held off until the vector is in, so no early interrupt
    irq_take_o <= any_irq & ~flags[`CC_MASK] &
      (vec_state == VS_DONE);
    irq_sel_o <= top_irq;
    branch_taken_o <= branch_i & cond_true;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `REG_ACCUMULATOR: reg_rdata_o <= accumulator;
        `REG_INDEX_UPPER: reg_rdata_o <= index_upper;
        `REG_INDEX_LOWER: reg_rdata_o <= index_lower;
        `REG_STACK_HIGH: reg_rdata_o <= stack_pointer[15:8];
        `REG_STACK_LOW: reg_rdata_o <= stack_pointer[7:0];
        `REG_PC_HIGH: reg_rdata_o <= program_counter[15:8];
        `REG_PC_LOW: reg_rdata_o <= program_counter[7:0];
        default: reg_rdata_o <= cc_view;
      endcase
    end else begin
      // zero outside the read slot keeps a shared read mux simple
      reg_rdata_o <= 8'h00;
    end
  end
end

endmodule // cpu_register_file_ccr

// ==== design/cpu_regs_map.vh ====
// register numbers, field positions, reset values and op codes of the cpu register file
`ifndef CPU_REGS_MAP_VH
`define CPU_REGS_MAP_VH
// register select on the software port
`define REG_ACCUMULATOR 3'h0
`define REG_INDEX_UPPER 3'h1
`define REG_INDEX_LOWER 3'h2
`define REG_STACK_HIGH 3'h3
`define REG_STACK_LOW 3'h4
`define REG_PC_HIGH 3'h5
`define REG_PC_LOW 3'h6
`define REG_CONDITION_CODES 3'h7
// condition code field positions
`define CC_CARRY 0
`define CC_ZERO 1
`define CC_NEGATIVE 2
`define CC_MASK 3
`define CC_HALF 4
`define CC_ONE_LO 5
`define CC_ONE_HI 6
`define CC_OVERFLOW 7
`define CC_FIXED_ONES 8'h60
// reset values
`define STACK_RESET 16'h00FF
`define STACK_LOW_RESET 8'hFF
`define CC_RESET 8'h68
`define VEC_HIGH_ADDR 16'hFFFE
`define VEC_LOW_ADDR 16'hFFFF
// alu operations
`define OP_NONE 4'h0
`define OP_ADD 4'h1
`define OP_ADC 4'h2
`define OP_SUB 4'h3
`define OP_SBC 4'h4
`define OP_AND 4'h5
`define OP_OR 4'h6
`define OP_EOR 4'h7
`define OP_LOAD 4'h8
`define OP_ASL 4'h9
`define OP_ASR 4'hA
`define OP_LSR 4'hB
`define OP_ROL 4'hC
`define OP_ROR 4'hD
`define OP_DAA 4'hE
`define OP_BIT_TEST 4'hF
// branch conditions; all but BR_ALWAYS look at the flags
`define BR_ALWAYS 3'h0
`define BR_GREATER 3'h1
`define BR_GREATER_EQUAL 3'h2
`define BR_LESS_EQUAL 3'h3
`define BR_LESS 3'h4
`define BR_EQUAL 3'h5
`define BR_NOT_EQUAL 3'h6
`define BR_CARRY 3'h7
`endif

// ==== sim/cpu_regs_properties.sv ====
// concurrent checks on the cpu register file ports
`timescale 1ns/1ns
`include "cpu_regs_map.vh"
module cpu_regs_properties (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire reg_rd_i,
  input wire reg_wr_i,
  input wire [7:0] reg_rdata_o,
  input wire vec_fetch_o,
  input wire [15:0] vec_addr_o,
  input wire fetch_i,
  input wire pc_load_i,
  input wire [15:0] pc_target_i,
  input wire branch_i,
  input wire push_i,
  input wire pull_i,
  input wire [2:0] pull_sel_i,
  input wire stack_reset_instr_i,
  input wire clear_mask_instr_i,
  input wire wait_stop_instr_i,
  input wire [15:0] stack_pointer_o,
  input wire [15:0] program_counter_o,
  input wire [7:0] condition_codes_o,
  input wire irq_take_o,
  input wire vector_ready_o
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // a same-cycle software write would override the step under test
  wire quiet = vector_ready_o && !reg_wr_i;
  wire unmask = clear_mask_instr_i || wait_stop_instr_i ||
    (pull_i && pull_sel_i == 3'h7);
  sequence s_vec_fetch;
    ##[0:2] (vec_fetch_o && vec_addr_o == `VEC_HIGH_ADDR)
      ##1 (vec_addr_o == `VEC_LOW_ADDR) ##[1:3] vector_ready_o;
  endsequence
  property p_vec_fetch;
    $rose(rst_b_i) |-> s_vec_fetch;
  endproperty
  a_vec_fetch: assert property (p_vec_fetch)
    else $error("vector fetch order wrong");
  property p_reset_values;
    $rose(rst_b_i) |-> stack_pointer_o == `STACK_RESET &&
      condition_codes_o == `CC_RESET;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("reset values wrong");
  property p_cc_ones;
    condition_codes_o[6:5] == 2'b11;
  endproperty
  a_cc_ones: assert property (p_cc_ones)
    else $error("fixed condition bits not one");
  property p_rdata_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
  property p_mask_clear;
    $fell(condition_codes_o[`CC_MASK]) |-> $past(unmask, 2);
  endproperty
  a_mask_clear: assert property (p_mask_clear)
    else $error("mask cleared without cause");
  property p_mask_blocks;
    condition_codes_o[`CC_MASK] |-> !irq_take_o;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("interrupt taken while masked");
  property p_stack_step;
    quiet && (push_i ^ pull_i) && !stack_reset_instr_i |-> ##2
      stack_pointer_o == $past(stack_pointer_o) +
      ($past(pull_i, 2) ? 16'h0001 : 16'hFFFF);
  endproperty
  a_stack_step: assert property (p_stack_step)
    else $error("stack pointer step wrong");
  property p_stack_reset;
    quiet && stack_reset_instr_i && !push_i && !pull_i |-> ##2
      stack_pointer_o == ($past(stack_pointer_o) | 16'h00FF);
  endproperty
  a_stack_reset: assert property (p_stack_reset)
    else $error("stack reset instruction wrong");
  property p_fetch;
    quiet && fetch_i && !pc_load_i && !branch_i |-> ##2
      program_counter_o == $past(program_counter_o) + 16'h0001;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch did not advance pc");
  property p_jump;
    quiet && pc_load_i |-> ##2 program_counter_o == $past(pc_target_i, 2);
  endproperty
  a_jump: assert property (p_jump)
    else $error("pc load wrong");
endmodule // cpu_regs_properties

// ==== sim/vector_rom_model.sv ====
// reset vector memory seen by the register file
`timescale 1ns/1ns
`include "cpu_regs_map.vh"
module vector_rom_model #(
  parameter [15:0] START = 16'hC040
) (
  input wire [15:0] vec_addr_i,
  output wire [7:0] vec_data_o
);
  // ----------------------------------------
  // lookup
  // ----------------------------------------
  // other addresses give a moving pattern so a stray pick shows
  assign vec_data_o = (vec_addr_i == `VEC_HIGH_ADDR) ? START[15:8] :
    (vec_addr_i == `VEC_LOW_ADDR) ? START[7:0] : ~vec_addr_i[7:0];
endmodule // vector_rom_model

// ==== sim/cpu_register_file_ccr_tb.sv ====
// self-checking bench for the cpu register file
`timescale 1ns/1ns
`include "cpu_regs_map.vh"
module cpu_register_file_ccr_tb;
  localparam [15:0] START = 16'hC040;
  localparam PUSH = 11'h400, PULL = 11'h200, SRST = 11'h100;
  localparam CLRM = 11'h080, SETM = 11'h040, WSTP = 11'h020;
  localparam STKD = 11'h010, FETCH = 11'h008, JUMP = 11'h004;
  localparam BRAN = 11'h002, TOIX = 11'h001;
  localparam [39:0] T_A = {8'h01, 8'hF0, 8'h00, 8'hFF, 8'h7F};
  localparam [39:0] T_D = {8'h01, 8'h0F, 8'h01, 8'h01, 8'h01};
  localparam [19:0] T_O = {`OP_LSR, `OP_AND, `OP_SUB, `OP_ADD, `OP_ADD};
  localparam [39:0] T_R = {8'h00, 8'h00, 8'hFF, 8'h00, 8'h80};
  localparam [39:0] T_K = {8'h87, 8'h86, 8'h87, 8'h97, 8'h97};
  localparam [39:0] T_F = {8'h83, 8'h02, 8'h05, 8'h13, 8'h94};
  reg core_clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg [2:0] reg_addr_i = 3'h0, pull_sel_i = 3'h0, branch_cond_i = 3'h0;
  reg [7:0] reg_wdata_i = 8'h00, operand_i = 8'h00, pull_data_i = 8'h00;
  reg [7:0] branch_offset_i = 8'h00;
  reg [3:0] alu_op_i = 4'h0, irq_req_i = 4'h0;
  reg [1:0] addr_mode_i = 2'h0;
  reg [15:0] pc_target_i = 16'h0000, offset_i = 16'h0010, exp16;
  reg reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  reg [10:0] ctl = 11'h000;
  wire push_i, pull_i, stack_reset_instr_i, clear_mask_instr_i;
  wire set_mask_instr_i, wait_stop_instr_i, stacking_done_i, fetch_i;
  wire pc_load_i, branch_i, alu_to_index_i;
  wire [7:0] reg_rdata_o, vec_data_i, accumulator_o, condition_codes_o;
  wire [15:0] vec_addr_o, index_pair_o, stack_pointer_o, program_counter_o;
  wire [15:0] operand_addr_o;
  wire vec_fetch_o, irq_take_o, branch_taken_o, vector_ready_o;
  wire [1:0] irq_sel_o;
  integer n_errors = 0, n_compared = 0, i;
  assign {push_i, pull_i, stack_reset_instr_i, clear_mask_instr_i,
    set_mask_instr_i, wait_stop_instr_i, stacking_done_i, fetch_i,
    pc_load_i, branch_i, alu_to_index_i} = ctl;
  always #2 core_clk_i = ~core_clk_i;
  cpu_register_file_ccr uut (.*);
  vector_rom_model #(.START(START)) rom (.vec_addr_i(vec_addr_o),
    .vec_data_o(vec_data_i));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, input [7:0] exp);
    begin
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge core_clk_i);
      check(reg_rdata_o, exp);
    end
  endtask
  // one cycle of sequencer controls, then settle two edges later
  task step(input [10:0] c, input [3:0] op, input [7:0] d);
    begin
      @(posedge core_clk_i);
      ctl <= c;
      alu_op_i <= op;
      operand_i <= d;
      pull_data_i <= d;
      @(posedge core_clk_i);
      ctl <= 11'h000;
      alu_op_i <= `OP_NONE;
      @(posedge core_clk_i);
      @(negedge core_clk_i);
    end
  endtask
  // one branch cycle; the taken flag stands only in the next cycle
  task br(input [2:0] c, input e);
    begin
      @(posedge core_clk_i);
      branch_cond_i <= c;
      ctl <= BRAN;
      @(posedge core_clk_i);
      ctl <= 11'h000;
      @(negedge core_clk_i);
      check(branch_taken_o, e);
    end
  endtask
  task complete_run;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    tick(16);
    rst_b_i <= 1'b1;
    for (i = 0; i < 20 && vector_ready_o !== 1'b1; i = i + 1)
      @(negedge core_clk_i);
    @(negedge core_clk_i);
    check(program_counter_o, START);
    check(stack_pointer_o, `STACK_RESET);
    rd(`REG_CONDITION_CODES, `CC_RESET);
    wr(`REG_CONDITION_CODES, 8'h00);
    rd(`REG_CONDITION_CODES, 8'h68);
    wr(`REG_INDEX_UPPER, 8'h12);
    wr(`REG_INDEX_LOWER, 8'h34);
    wr(`REG_STACK_HIGH, 8'h02);
    rd(`REG_INDEX_UPPER, 8'h12);
    check(index_pair_o, 16'h1234);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge core_clk_i);
      addr_mode_i <= i[1:0];
      exp16 = i == 0 ? 16'h0010 : i == 1 ? 16'h1244 : 16'h030F;
      tick(3);
      @(negedge core_clk_i);
      check(operand_addr_o, exp16);
    end
    step(PUSH, `OP_NONE, 8'h00);
    step(PUSH, `OP_NONE, 8'h00);
    check(stack_pointer_o, 16'h02FD);
    step(SRST, `OP_NONE, 8'h00);
    check(stack_pointer_o, 16'h02FF);
    step(PULL, `OP_NONE, 8'h5A);
    check(stack_pointer_o, 16'h0300);
    check(accumulator_o, 8'h5A);
    @(posedge core_clk_i);
    pull_sel_i <= `REG_INDEX_UPPER;
    step(PULL, `OP_NONE, 8'h3C);
    check(index_pair_o, 16'h3C34);
    for (i = 0; i < 5; i = i + 1) begin
      wr(`REG_ACCUMULATOR, T_A[8*i +: 8]);
      step(11'h000, T_O[4*i +: 4], T_D[8*i +: 8]);
      check(accumulator_o, T_R[8*i +: 8]);
      check(condition_codes_o & T_K[8*i +: 8], T_F[8*i +: 8]);
    end
    wr(`REG_ACCUMULATOR, 8'h09);
    step(11'h000, `OP_ADD, 8'h08);
    check(condition_codes_o & 8'h11, 8'h10);
    step(11'h000, `OP_DAA, 8'h00);
    check(accumulator_o, 8'h17);
    step(TOIX, `OP_LOAD, 8'hA5);
    check(index_pair_o[7:0], 8'hA5);
    step(FETCH, `OP_NONE, 8'h00);
    check(program_counter_o, START + 16'h0001);
    @(posedge core_clk_i);
    branch_offset_i <= 8'hFC;
    pc_target_i <= 16'h8000;
    step(BRAN, `OP_NONE, 8'h00);
    check(program_counter_o, START - 16'h0002);
    step(JUMP, `OP_NONE, 8'h00);
    check(program_counter_o, 16'h8000);
    br(`BR_LESS, 1'b1);
    br(`BR_GREATER_EQUAL, 1'b0);
    @(posedge core_clk_i);
    irq_req_i <= 4'b0110;
    tick(3);
    @(negedge core_clk_i);
    check(irq_take_o, 1'b0);
    step(CLRM, `OP_NONE, 8'h00);
    @(negedge core_clk_i);
    check(irq_take_o, 1'b1);
    check(irq_sel_o, 2'h1);
    step(STKD, `OP_NONE, 8'h00);
    check(condition_codes_o[`CC_MASK], 1'b1);
    @(posedge core_clk_i);
    pull_sel_i <= 3'h7;
    step(PULL, `OP_NONE, 8'h00);
    check(condition_codes_o, 8'h60);
    step(SETM, `OP_NONE, 8'h00);
    step(WSTP, `OP_NONE, 8'h00);
    check(condition_codes_o[`CC_MASK], 1'b0);
    // wake by reset in mid-run: mask set again, vector reloaded
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    tick(4);
    rst_b_i <= 1'b1;
    tick(5);
    @(negedge core_clk_i);
    check(condition_codes_o, `CC_RESET);
    check(irq_take_o, 1'b0);
    check(stack_pointer_o, `STACK_RESET);
    check(program_counter_o, START);
    complete_run;
  end
  initial begin
    tick(5000);
    n_errors = n_errors + 1;
    complete_run;
  end
endmodule // cpu_register_file_ccr_tb
bind cpu_register_file_ccr cpu_regs_properties chk (.*);
